// ### common/ebld_pkg.sv
package ebld_pkg;

    // Register field codes.
    localparam logic [2:0] REG_B = 3'h0;
    localparam logic [2:0] REG_C = 3'h1;
    localparam logic [2:0] REG_D = 3'h2;
    localparam logic [2:0] REG_E = 3'h3;
    localparam logic [2:0] REG_H = 3'h4;
    localparam logic [2:0] REG_L = 3'h5;
    localparam logic [2:0] REG_MEM = 3'h6;
    localparam logic [2:0] REG_A = 3'h7;

    // Prefix bytes and opcode field positions.
    localparam logic [7:0] PFX_FIRST = 8'hdd;
    localparam logic [7:0] PFX_SECOND = 8'hfd;
    localparam int DST_MSB = 5;
    localparam int DST_LSB = 3;
    localparam int SRC_MSB = 2;
    localparam int SRC_LSB = 0;
    localparam logic [1:0] GRP_MOVE = 2'h1;
    localparam logic [1:0] GRP_IMM = 2'h0;
    localparam logic [2:0] IMM_LOW = 3'h6;

    // Clock states per machine cycle.
    localparam logic [2:0] T_FETCH = 3'h4;
    localparam logic [2:0] T_MEM = 3'h3;
    localparam logic [2:0] T_ADDR = 3'h5;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    typedef enum logic [6:0] {
        ST_FETCH = 7'h01,
        ST_PFX_FETCH = 7'h02,
        ST_DISP = 7'h04,
        ST_ADDR = 7'h08,
        ST_IMM = 7'h10,
        ST_READ = 7'h20,
        ST_WRITE = 7'h40
    } ebld_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ebld_bus_t;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] f;
        logic [7:0] b;
        logic [7:0] c;
        logic [7:0] d;
        logic [7:0] e;
        logic [7:0] h;
        logic [7:0] l;
        logic [15:0] index_reg_first;
        logic [15:0] index_reg_second;
    } ebld_regs_t;

endpackage

// ### hdl/ebld_decoder.sv
// Operation
// - Instructions run as machine cycles of states.
// - Field 111 is A, 000-101 B..L.
// - Register move copies source, four states.
// - Immediate load fetches next byte, 4+3.
// - Load through pointer pair reads memory, 4+3.
// - Store through pointer pair writes memory, 4+3.
// - First prefix, opcode, displacement add signed.
// - Second index load, 4,4,3,5,3 states.
// - First index store writes at index plus displacement.
// - Second index store writes at index plus displacement.
module ebld_decoder (
    input wire logic clk, // Clock, one clock state per cycle.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [7:0] fetch_data, // Opcode or operand byte from the fetch unit.
    input wire logic [7:0] mem_rdata, // Data returned by a memory read cycle.
    output ebld_pkg::ebld_bus_t bus_q, // Memory request for the current machine cycle.
    output logic fetch_q, // High during an opcode or operand fetch cycle.
    output logic m1_q, // High during the clock states of an opcode fetch.
    output logic done_q, // One-cycle pulse as an instruction retires.
    output logic [15:0] pc_q, // Address of the next byte to fetch.
    output ebld_pkg::ebld_regs_t regs_q, // Architectural register file.
    output logic illegal_q // Level: the last opcode was outside the load group.
);

    ebld_pkg::ebld_state_t state_q, state_d;
    logic [2:0] tcnt_q;
    logic [7:0] op_q;
    logic [1:0] pfx_q; // Bit 0 marks the first index, bit 1 the second.
    logic [7:0] disp_q;

    ////////////////////////////////////////////////////////////////////////
    // Register field helpers.

    function automatic logic [7:0] reg_read(input ebld_pkg::ebld_regs_t r,
                                            input logic [2:0] sel);
        case (sel)
            ebld_pkg::REG_B: reg_read = r.b;
            ebld_pkg::REG_C: reg_read = r.c;
            ebld_pkg::REG_D: reg_read = r.d;
            ebld_pkg::REG_E: reg_read = r.e;
            ebld_pkg::REG_H: reg_read = r.h;
            ebld_pkg::REG_L: reg_read = r.l;
            ebld_pkg::REG_A: reg_read = r.a;
            default: reg_read = ebld_pkg::RST_BYTE;
        endcase
    endfunction

    function automatic ebld_pkg::ebld_regs_t reg_write(input ebld_pkg::ebld_regs_t r,
                                                      input logic [2:0] sel,
                                                      input logic [7:0] v);
        ebld_pkg::ebld_regs_t n;
        n = r;
        case (sel)
            ebld_pkg::REG_B: n.b = v;
            ebld_pkg::REG_C: n.c = v;
            ebld_pkg::REG_D: n.d = v;
            ebld_pkg::REG_E: n.e = v;
            ebld_pkg::REG_H: n.h = v;
            ebld_pkg::REG_L: n.l = v;
            ebld_pkg::REG_A: n.a = v;
            default: n = r;
        endcase
        reg_write = n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Opcode decode from the byte in hand.

    wire logic [7:0] opc = (state_q == ebld_pkg::ST_FETCH ||
                            state_q == ebld_pkg::ST_PFX_FETCH) ? fetch_data : op_q;
    wire logic [2:0] dst = opc[ebld_pkg::DST_MSB:ebld_pkg::DST_LSB];
    wire logic [2:0] src = opc[ebld_pkg::SRC_MSB:ebld_pkg::SRC_LSB];
    wire logic is_move = opc[7:6] == ebld_pkg::GRP_MOVE;
    // Code 76 (both fields memory) is the halt slot and is not a load.
    wire logic is_halt = is_move && dst == ebld_pkg::REG_MEM && src == ebld_pkg::REG_MEM;
    wire logic is_imm = opc[7:6] == ebld_pkg::GRP_IMM && src == ebld_pkg::IMM_LOW &&
                        dst != ebld_pkg::REG_MEM;
    wire logic mem_src = is_move && src == ebld_pkg::REG_MEM && !is_halt;
    wire logic mem_dst = is_move && dst == ebld_pkg::REG_MEM && !is_halt;
    wire logic reg_move = is_move && !mem_src && !mem_dst && !is_halt;
    wire logic is_pfx = fetch_data == ebld_pkg::PFX_FIRST ||
                        fetch_data == ebld_pkg::PFX_SECOND;
    wire logic [15:0] ptr = {regs_q.h, regs_q.l};
    wire logic [15:0] idx = pfx_q[1] ? regs_q.index_reg_second : regs_q.index_reg_first;
    // Sign extension lets a displacement reach 128 below the index.
    wire logic [15:0] idx_ea = idx + {{8{disp_q[7]}}, disp_q};
    wire logic last_t = tcnt_q == 3'h1;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: each state holds for its clock-state count.

    logic [2:0] tlen_d;
    always_comb
    begin
        state_d = state_q;
        tlen_d = ebld_pkg::T_FETCH;
        case (state_q)
            ebld_pkg::ST_FETCH, ebld_pkg::ST_PFX_FETCH:
            begin
                if (state_q == ebld_pkg::ST_FETCH && is_pfx)
                    state_d = ebld_pkg::ST_PFX_FETCH;
                else if (state_q == ebld_pkg::ST_PFX_FETCH && (mem_src || mem_dst))
                begin
                    state_d = ebld_pkg::ST_DISP;
                    tlen_d = ebld_pkg::T_MEM;
                end
                else if (is_imm)
                begin
                    state_d = ebld_pkg::ST_IMM;
                    tlen_d = ebld_pkg::T_MEM;
                end
                else if (mem_src)
                begin
                    state_d = ebld_pkg::ST_READ;
                    tlen_d = ebld_pkg::T_MEM;
                end
                else if (mem_dst)
                begin
                    state_d = ebld_pkg::ST_WRITE;
                    tlen_d = ebld_pkg::T_MEM;
                end
                else
                    state_d = ebld_pkg::ST_FETCH;
            end
            ebld_pkg::ST_DISP:
            begin
                state_d = ebld_pkg::ST_ADDR;
                tlen_d = ebld_pkg::T_ADDR;
            end
            ebld_pkg::ST_ADDR:
            begin
                state_d = mem_src ? ebld_pkg::ST_READ : ebld_pkg::ST_WRITE;
                tlen_d = ebld_pkg::T_MEM;
            end
            ebld_pkg::ST_IMM, ebld_pkg::ST_READ, ebld_pkg::ST_WRITE:
                state_d = ebld_pkg::ST_FETCH;
            default:
                state_d = ebld_pkg::ST_FETCH;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus request for the state that is starting.

    ebld_pkg::ebld_bus_t bus_d;
    always_comb
    begin
        bus_d = '0;
        case (state_d)
            ebld_pkg::ST_READ:
            begin
                bus_d.rd = 1'b1;
                bus_d.addr = (state_q == ebld_pkg::ST_ADDR) ? idx_ea : ptr;
            end
            ebld_pkg::ST_WRITE:
            begin
                bus_d.wr = 1'b1;
                bus_d.addr = (state_q == ebld_pkg::ST_ADDR) ? idx_ea : ptr;
                bus_d.wdata = reg_read(regs_q, src);
            end
            default:
                bus_d = '0;
        endcase
    end

    wire logic advance = last_t;
    wire logic fetching = state_q == ebld_pkg::ST_FETCH || state_q == ebld_pkg::ST_PFX_FETCH ||
                          state_q == ebld_pkg::ST_DISP || state_q == ebld_pkg::ST_IMM;
    wire logic retire = advance && (state_d == ebld_pkg::ST_FETCH) &&
                        !(state_q == ebld_pkg::ST_FETCH && is_pfx);

    ////////////////////////////////////////////////////////////////////////
    // Register file update at the end of each machine cycle.

    ebld_pkg::ebld_regs_t regs_d;
    always_comb
    begin
        regs_d = regs_q;
        if (advance)
        begin
            case (state_q)
                ebld_pkg::ST_FETCH, ebld_pkg::ST_PFX_FETCH:
                    if (reg_move)
                        regs_d = reg_write(regs_q, dst, reg_read(regs_q, src));
                ebld_pkg::ST_IMM:
                    regs_d = reg_write(regs_q, dst, fetch_data);
                ebld_pkg::ST_READ:
                    regs_d = reg_write(regs_q, dst, mem_rdata);
                default:
                    regs_d = regs_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next values of the registered outputs.

    wire logic in_fetch = state_q == ebld_pkg::ST_FETCH || state_q == ebld_pkg::ST_PFX_FETCH;
    wire logic first_fetch = state_q == ebld_pkg::ST_FETCH;
    wire logic fetch_d = state_d != ebld_pkg::ST_ADDR && state_d != ebld_pkg::ST_READ &&
                         state_d != ebld_pkg::ST_WRITE;
    wire logic m1_d = state_d == ebld_pkg::ST_FETCH || state_d == ebld_pkg::ST_PFX_FETCH;
    wire logic [1:0] pfx_d = is_pfx ? {fetch_data == ebld_pkg::PFX_SECOND,
                                       fetch_data == ebld_pkg::PFX_FIRST} : 2'h0;
    // A prefix byte in the first fetch is not yet an opcode, so there it does not raise the flag.
    wire logic illegal_d = !(is_pfx && first_fetch) &&
                           !(reg_move || is_imm || mem_src || mem_dst);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state and clock-state counter.

    // The counter loads the length of the coming cycle and counts down to one.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ebld_pkg::ST_FETCH;
            tcnt_q <= ebld_pkg::T_FETCH;
        end
        else if (advance)
        begin
            state_q <= state_d;
            tcnt_q <= tlen_d;
        end
        else
            tcnt_q <= tcnt_q - 3'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus request and cycle markers.

    // Changing them only at a cycle boundary keeps address and data steady for memory.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_q <= '0;
            fetch_q <= 1'b1;
            m1_q <= 1'b1;
        end
        else if (advance)
        begin
            bus_q <= bus_d;
            fetch_q <= fetch_d;
            m1_q <= m1_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Retire pulse and register file.

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            done_q <= 1'b0;
            regs_q <= '0;
        end
        else
        begin
            done_q <= retire;
            regs_q <= regs_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter: one step per fetched byte, none during memory cycles.

    always_ff @(posedge clk)
    begin
        if (rst)
            pc_q <= ebld_pkg::RST_WORD;
        else if (advance && fetching)
            pc_q <= pc_q + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Opcode, prefix and displacement capture.

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            op_q <= ebld_pkg::RST_BYTE;
            pfx_q <= 2'h0;
            disp_q <= ebld_pkg::RST_BYTE;
            illegal_q <= 1'b0;
        end
        else if (advance)
        begin
            if (first_fetch)
                pfx_q <= pfx_d;
            if (in_fetch)
            begin
                op_q <= fetch_data;
                illegal_q <= illegal_d;
            end
            if (state_q == ebld_pkg::ST_DISP)
                disp_q <= fetch_data;
        end
    end

endmodule

// ### testbench/ebld_decoder_assertions.sv
module ebld_decoder_chk (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire ebld_pkg::ebld_bus_t bus_q, // bus cycle
    input wire logic fetch_q, // fetch cycle
    input wire logic m1_q, // opcode fetch
    input wire logic done_q, // retire pulse
    input wire logic [15:0] pc_q, // program counter
    input wire ebld_pkg::ebld_regs_t regs_q // registers
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    wire idle_w = !bus_q.rd && !bus_q.wr;
////////////////////////////////////////////////////////////////////////////////
    property p_m1_len;
        $rose(m1_q) |-> m1_q [*4];
    endproperty
    a_m1_len: assert property (p_m1_len) else $error("opcode fetch too short");
    property p_rd_len;
        $rose(bus_q.rd) |-> bus_q.rd [*3] ##1 !bus_q.rd;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read cycle not three states");
    property p_wr_len;
        $rose(bus_q.wr) |-> bus_q.wr [*3] ##1 !bus_q.wr;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write cycle not three states");
    property p_wr_done;
        $fell(bus_q.wr) |-> done_q;
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("store did not retire");
    property p_addr_len;
        (fetch_q ##1 (!fetch_q && idle_w)) |-> idle_w [*5] ##1 !idle_w;
    endproperty
    a_addr_len: assert property (p_addr_len) else $error("address cycle not five states");
    property p_flags;
        regs_q.f == 8'h00;
    endproperty
    a_flags: assert property (p_flags) else $error("flag register changed");
    property p_pc_hold;
        !fetch_q |=> pc_q == $past(pc_q);
    endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("pc moved outside fetch");
    property p_pc_inc;
        $fell(fetch_q) |-> pc_q == $past(pc_q) + 16'h0001;
    endproperty
    a_pc_inc: assert property (p_pc_inc) else $error("pc not stepped by one");
////////////////////////////////////////////////////////////////////////////////
    c_read: cover property ($fell(bus_q.rd));
    c_write: cover property ($fell(bus_q.wr));
    c_index: cover property (fetch_q ##1 (!fetch_q && idle_w));
endmodule

bind ebld_decoder ebld_decoder_chk u_chk (
    .clk(clk),
    .rst(rst),
    .bus_q(bus_q),
    .fetch_q(fetch_q),
    .m1_q(m1_q),
    .done_q(done_q),
    .pc_q(pc_q),
    .regs_q(regs_q)
);

// ### testbench/ebld_decoder_test.sv
module ebld_decoder_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] fetch_data;
    logic [7:0] mem_rdata;
    ebld_pkg::ebld_bus_t bus_q;
    logic fetch_q, m1_q, done_q, illegal_q;
    logic [15:0] pc_q;
    ebld_pkg::ebld_regs_t regs_q;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    int wp;
    int lens[$];
    ebld_decoder uut (.clk(clk), .rst(rst), .fetch_data(fetch_data), .mem_rdata(mem_rdata),
        .bus_q(bus_q), .fetch_q(fetch_q), .m1_q(m1_q), .done_q(done_q), .pc_q(pc_q),
        .regs_q(regs_q), .illegal_q(illegal_q));
    ebld_mem_model u_mem (.clk(clk), .pc_q(pc_q), .bus_q(bus_q), .fetch_data(fetch_data),
        .mem_rdata(mem_rdata));
    always #20 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("TB: %0d checks, %0d mismatches", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    // Unused space holds a legal move, so a run past the program stays harmless.
    task automatic clear();
        for (int i = 0; i < 65536; i++)
            u_mem.mem[i] = 8'h40;
        wp = 0;
        lens.delete();
    endtask
    task automatic ins(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
            input int nb, input int len);
        logic [7:0] b [3];
        b = '{b0, b1, b2};
        for (int i = 0; i < nb; i++)
            u_mem.mem[wp + i] = b[i];
        wp += nb;
        lens.push_back(len);
    endtask
    // Each gap between retire pulses must equal the instruction's state count.
    task automatic run();
        int t;
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        foreach (lens[k])
        begin
            t = 0;
            do
            begin
                @(posedge clk);
                #1 t++;
            end while (done_q !== 1'b1 && t < 40);
            check(16'(t), 16'(lens[k]));
        end
        check(regs_q.f, 8'h00);
    endtask
////////////////////////////////////////////////////////////////////////////////
    task automatic t_reg();
        clear();
        for (int r = 0; r < 8; r++)
            if (r != 6)
                ins({2'b00, 3'(r), 3'b110}, 8'(8'h11 * (r + 1)), 8'h00, 2, 7);
        ins(8'h6f, 8'h00, 8'h00, 1, 4);
        ins(8'h78, 8'h00, 8'h00, 1, 4);
        ins(8'h76, 8'h00, 8'h00, 1, 4);
        run();
        check(regs_q.b, 8'h11);
        check(regs_q.e, 8'h44);
        check(regs_q.h, 8'h55);
        check(regs_q.l, 8'h88);
        check(regs_q.a, 8'h11);
        check(illegal_q, 1'b1);
        $display("TB: register test done");
    endtask
    task automatic t_ptr();
        clear();
        u_mem.mem[16'h1234] = 8'ha7;
        ins(8'h26, 8'h12, 8'h00, 2, 7);
        ins(8'h2e, 8'h34, 8'h00, 2, 7);
        ins(8'h1e, 8'h9c, 8'h00, 2, 7);
        ins(8'h56, 8'h00, 8'h00, 1, 7);
        ins(8'h73, 8'h00, 8'h00, 1, 7);
        ins(8'h7e, 8'h00, 8'h00, 1, 7);
        run();
        check(regs_q.d, 8'ha7);
        check(u_mem.mem[16'h1234], 8'h9c);
        check(regs_q.a, 8'h9c);
        $display("TB: pointer test done");
    endtask
    task automatic t_idx();
        clear();
        u_mem.mem[16'hff80] = 8'hc3;
        u_mem.mem[16'h007f] = 8'h3c;
        ins(8'h3e, 8'h5a, 8'h00, 2, 7);
        ins(8'hdd, 8'h46, 8'h80, 3, 19);
        ins(8'hfd, 8'h4e, 8'h7f, 3, 19);
        ins(8'hdd, 8'h77, 8'hfe, 3, 19);
        ins(8'hfd, 8'h71, 8'h10, 3, 19);
        run();
        check(regs_q.b, 8'hc3);
        check(regs_q.c, 8'h3c);
        check(u_mem.mem[16'hfffe], 8'h5a);
        check(u_mem.mem[16'h0010], 8'h3c);
        $display("TB: index test done");
    endtask
    initial
    begin
        clear();
        t_reg();
        t_ptr();
        t_idx();
        complete_run();
    end
endmodule

// ### testbench/ebld_mem_model.sv
module ebld_mem_model (
    input wire logic clk, // clock
    input wire logic [15:0] pc_q, // fetch address
    input wire ebld_pkg::ebld_bus_t bus_q, // bus request
    output logic [7:0] fetch_data, // fetch byte
    output logic [7:0] mem_rdata // read byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    // Outside a read the lines show the inverse of the last byte, so stale data cannot pass.
    assign mem_rdata = bus_q.rd ? mem[bus_q.addr] : ~last_q;
    assign fetch_data = mem[pc_q];
    always @(posedge clk)
    begin
        if (bus_q.rd)
            last_q <= mem[bus_q.addr];
        if (bus_q.wr)
            mem[bus_q.addr] <= bus_q.wdata;
    end
endmodule
